// [hdl/uvs_gain_map.sv]
/*
 * Maps a volume index to gain in dB for bridge or single-ended output.
 * Assumes index 0 is mute and each higher index adds one 2 dB step.
 */
`timescale 1ns/1ns
`include "uvs_params.svh"
module uvs_gain_map (
    input wire logic [4:0] idx_in,
    input wire logic se_in,
    output logic [7:0] gain_out
);
    logic [7:0] bridge;

    always_comb begin
        // Bridge: 20 dB down to -40 dB, then mute
        if (idx_in == `UVS_IDX_MUTE) begin
            bridge = `UVS_GAIN_MUTE_DB;
        end else begin
            bridge = 8'({3'h0, idx_in, 1'b0}) - `UVS_GAIN_OFFSET_DB;
        end
        // Single-ended is 6 dB lower
        gain_out = se_in ? (bridge - `UVS_SE_DROP_DB) : bridge;
    end

endmodule

// [hdl/uvs_params.svh]
/*
 * Constants of the up/down volume stepper: index codes, gain mapping and
 * the press-and-hold ramp schedule, counted in edges of the volume clock pin.
 * Assumes the nominal internal oscillator rate given below.
 */
`ifndef UVS_PARAMS_SVH
`define UVS_PARAMS_SVH

// Volume index codes
`define UVS_IDX_MUTE 5'h00
`define UVS_IDX_MAX 5'h1F
`define UVS_IDX_RET_DEFAULT 5'h10

// Gain mapping in dB, two's complement
`define UVS_GAIN_OFFSET_DB 8'h2A
`define UVS_GAIN_MUTE_DB 8'hAB
`define UVS_GAIN_TOP_DB 8'h14
`define UVS_SE_DROP_DB 8'h06

// Clock pin edges per step without ramp delay
`define UVS_STEP_EDGES 32'h0000_0004

// Internal oscillator nominal rate and ramp intervals (40, 400, 200, 120, 80 ms)
`define UVS_INT_CLK_HZ 32'h0000_0064
`define UVS_MS_PER_S 32'h0000_03E8
`define UVS_T_FIRST_MS 32'h0000_0028
`define UVS_T_SECOND_MS 32'h0000_0190
`define UVS_T_THIRD_MS 32'h0000_00C8
`define UVS_T_FOURTH_MS 32'h0000_0078
`define UVS_T_FIFTH_MS 32'h0000_0050

`define UVS_CYC_FIRST ((`UVS_T_FIRST_MS * `UVS_INT_CLK_HZ) / `UVS_MS_PER_S)
`define UVS_CYC_SECOND ((`UVS_T_SECOND_MS * `UVS_INT_CLK_HZ) / `UVS_MS_PER_S)
`define UVS_CYC_THIRD ((`UVS_T_THIRD_MS * `UVS_INT_CLK_HZ) / `UVS_MS_PER_S)
`define UVS_CYC_FOURTH ((`UVS_T_FOURTH_MS * `UVS_INT_CLK_HZ) / `UVS_MS_PER_S)
`define UVS_CYC_FIFTH ((`UVS_T_FIFTH_MS * `UVS_INT_CLK_HZ) / `UVS_MS_PER_S)

`endif

// [hdl/uvs_pin_sync.sv]
/*
 * Three-stage synchroniser for the device pins. The held level follows a
 * change once the second and third stages agree.
 * Assumes pins are asynchronous to ref_clk_in.
 */
`timescale 1ns/1ns
module uvs_pin_sync
    import uvs_pkg::*;
#(
    parameter uvs_pins_s RST_VAL = '0
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire uvs_pins_s pins_in,
    output uvs_pins_s pins_out
);
    localparam int W = $bits(uvs_pins_s);

    logic [W-1:0] st1;
    logic [W-1:0] st2;
    logic [W-1:0] st3;
    logic [W-1:0] held;
    logic [W-1:0] next_held;

    // Accept a new level only when stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign next_held[i] = (st2[i] == st3[i]) ? st3[i] : held[i];
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st1 <= RST_VAL;
            st2 <= RST_VAL;
            st3 <= RST_VAL;
            held <= RST_VAL;
        end else if (ce_in) begin
            st1 <= pins_in;
            st2 <= st1;
            st3 <= st2;
            held <= next_held;
        end
    end

    assign pins_out = held;

endmodule

// [hdl/uvs_pkg.sv]
/*
 * Types shared by the volume stepper modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uvs_pkg;

    // Pin levels as seen inside the device
    typedef struct packed {
        logic vol_clk;
        logic up_n;
        logic down_n;
        logic ext_mode;
        logic se_mode;
        logic ret_ok;
        logic main_power;
    } uvs_pins_s;

    // Ramp position: interval expected before the next step
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_FIRST,
        PH_SECOND,
        PH_THIRD,
        PH_FOURTH,
        PH_FIFTH,
        PH_REPEAT
    } uvs_phase_e;

endpackage

// [hdl/uvs_updown_stepper.sv]
/*
 * Up/down volume stepper: samples the volume clock pin and the two request
 * pins, runs the press-and-hold ramp or the plain external-clock edge count,
 * and keeps a saturating 32-entry volume index with its gain.
 * Assumes all pins are asynchronous and slow against ref_clk_in; rst_n_in
 * marks the first power-up of the retention supply.
 */
// Summary of operation
// - First power-up without retained setting starts at the mute entry.
// - Each accepted request with increase pin low raises gain one 2 dB step.
// - Each accepted request with decrease pin low lowers gain one 2 dB step.
// - Internal clock: step after four low samples, then a delay follows.
// - Ramp: first step 40 ms, second 400 ms later, third 200 ms later.
// - Fourth step 120 ms later, fifth 80 ms later, then every four cycles.
// - Pins sampled on rising clock edges; volume changes after completing edge.
// - External clock: no ramp delays, every four low edges give a step.
// - External edge count persists between requests; surplus carries forward.
// - Index survives main power loss while retention supply stays up.
// - Retention loss loads the -10 dB bridge entry (-16 dB single-ended).
`timescale 1ns/1ns
`include "uvs_params.svh"
module uvs_updown_stepper
    import uvs_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic vol_clk_pin_in,
    input wire logic vol_up_n_in,
    input wire logic vol_down_n_in,
    input wire logic clk_source_ext_in,
    input wire logic output_config_select_in,
    input wire logic retention_supply_ok_in,
    input wire logic main_power_ok_in,
    output logic [4:0] vol_index_out,
    output logic [7:0] gain_db_out,
    output logic mute_out,
    output logic step_up_out,
    output logic step_down_out
);
    localparam uvs_pins_s PINS_IDLE = '{
        vol_clk: 1'b0, up_n: 1'b1, down_n: 1'b1, ext_mode: 1'b0,
        se_mode: 1'b0, ret_ok: 1'b1, main_power: 1'b0};

    uvs_pins_s raw_pins;
    uvs_pins_s pins;

    logic clk_prev;
    logic next_clk_prev;
    logic clk_rise;
    logic req_up;
    logic req_down;
    logic dir_valid;

    uvs_phase_e phase;
    uvs_phase_e next_phase;
    uvs_phase_e base_phase;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [5:0] base_cnt;
    logic [2:0] ext_cnt;
    logic [2:0] next_ext_cnt;
    logic held_up;
    logic next_held_up;
    logic do_step;

    logic [4:0] idx;
    logic [4:0] next_idx;
    logic [7:0] next_gain;
    logic next_mute;
    logic next_step_up;
    logic next_step_down;

    // Interval length in clock pin edges for each ramp position
    function automatic logic [5:0] interval(input uvs_phase_e ph);
        logic [5:0] r;
        r = 6'(`UVS_STEP_EDGES);
        unique case (ph)
            PH_IDLE: r = 6'(`UVS_STEP_EDGES);
            PH_FIRST: r = 6'(`UVS_CYC_FIRST);
            PH_SECOND: r = 6'(`UVS_CYC_SECOND);
            PH_THIRD: r = 6'(`UVS_CYC_THIRD);
            PH_FOURTH: r = 6'(`UVS_CYC_FOURTH);
            PH_FIFTH: r = 6'(`UVS_CYC_FIFTH);
            PH_REPEAT: r = 6'(`UVS_STEP_EDGES);
        endcase
        return r;
    endfunction

    // Ramp position after a step
    function automatic uvs_phase_e advance(input uvs_phase_e ph);
        uvs_phase_e r;
        r = PH_REPEAT;
        unique case (ph)
            PH_IDLE: r = PH_FIRST;
            PH_FIRST: r = PH_SECOND;
            PH_SECOND: r = PH_THIRD;
            PH_THIRD: r = PH_FOURTH;
            PH_FOURTH: r = PH_FIFTH;
            PH_FIFTH: r = PH_REPEAT;
            PH_REPEAT: r = PH_REPEAT;
        endcase
        return r;
    endfunction

    assign raw_pins = '{
        vol_clk: vol_clk_pin_in, up_n: vol_up_n_in, down_n: vol_down_n_in,
        ext_mode: clk_source_ext_in, se_mode: output_config_select_in,
        ret_ok: retention_supply_ok_in, main_power: main_power_ok_in};

    uvs_pin_sync #(
        .RST_VAL(PINS_IDLE)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .pins_in(raw_pins),
        .pins_out(pins)
    );

    // Rising edge of the volume clock and request decode
    always_comb begin
        next_clk_prev = pins.vol_clk;
        clk_rise = pins.vol_clk && !clk_prev;
        req_up = !pins.up_n;
        req_down = !pins.down_n;
        dir_valid = req_up ^ req_down;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_prev <= 1'b0;
        end else if (ce_in) begin
            clk_prev <= next_clk_prev;
        end
    end

    // Step scheduler
    always_comb begin
        next_phase = phase;
        next_cnt = cnt;
        next_ext_cnt = ext_cnt;
        next_held_up = held_up;
        base_phase = phase;
        base_cnt = cnt;
        do_step = 1'b0;
        if (pins.main_power) begin
            if (pins.ext_mode) begin
                next_phase = PH_IDLE;
                next_cnt = 6'h00;
                // Count persists across requests, no ramp delay
                if (dir_valid && clk_rise) begin
                    if (ext_cnt == 3'(`UVS_STEP_EDGES - 1)) begin
                        do_step = 1'b1;
                        next_ext_cnt = 3'h0;
                    end else begin
                        next_ext_cnt = ext_cnt + 3'h1;
                    end
                end
            end else if (!dir_valid) begin
                next_phase = PH_IDLE;
                next_cnt = 6'h00;
            end else begin
                // New press or direction change restarts the ramp
                if (phase == PH_IDLE || req_up != held_up) begin
                    base_phase = PH_FIRST;
                    base_cnt = 6'h00;
                end
                next_held_up = req_up;
                next_phase = base_phase;
                next_cnt = base_cnt;
                if (clk_rise) begin
                    if (base_cnt == interval(base_phase) - 6'h01) begin
                        do_step = 1'b1;
                        next_cnt = 6'h00;
                        next_phase = advance(base_phase);
                    end else begin
                        next_cnt = base_cnt + 6'h01;
                    end
                end
            end
        end else begin
            // Power loss drops any ramp in progress
            next_phase = PH_IDLE;
            next_cnt = 6'h00;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase <= PH_IDLE;
            cnt <= 6'h00;
            ext_cnt <= 3'h0;
            held_up <= 1'b0;
        end else if (ce_in) begin
            phase <= next_phase;
            cnt <= next_cnt;
            ext_cnt <= next_ext_cnt;
            held_up <= next_held_up;
        end
    end

    // Volume index and outputs
    always_comb begin
        next_idx = idx;
        next_step_up = 1'b0;
        next_step_down = 1'b0;
        if (!pins.ret_ok) begin
            next_idx = `UVS_IDX_RET_DEFAULT;
        end else if (do_step) begin
            if (req_up && idx != `UVS_IDX_MAX) begin
                next_idx = idx + 5'h01;
                next_step_up = 1'b1;
            end else if (req_down && idx != `UVS_IDX_MUTE) begin
                next_idx = idx - 5'h01;
                next_step_down = 1'b1;
            end
        end
        next_mute = (next_idx == `UVS_IDX_MUTE);
    end

    uvs_gain_map u_map (
        .idx_in(next_idx),
        .se_in(pins.se_mode),
        .gain_out(next_gain)
    );

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idx <= `UVS_IDX_MUTE;
            gain_db_out <= `UVS_GAIN_MUTE_DB;
            mute_out <= 1'b1;
            step_up_out <= 1'b0;
            step_down_out <= 1'b0;
        end else if (ce_in) begin
            idx <= next_idx;
            gain_db_out <= next_gain;
            mute_out <= next_mute;
            step_up_out <= next_step_up;
            step_down_out <= next_step_down;
        end
    end

    assign vol_index_out = idx;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    init_mute_a: assert property ($rose(rst_n_in) |-> idx == `UVS_IDX_MUTE)
        else $error("index not at mute after reset");

    up_step_a: assert property (ce_in && pins.ret_ok && do_step && req_up
        && idx != `UVS_IDX_MAX |=> idx == $past(idx) + 5'h01 && step_up_out)
        else $error("increase step not applied");

    down_step_a: assert property (ce_in && pins.ret_ok && do_step && req_down
        && idx != `UVS_IDX_MUTE |=> idx == $past(idx) - 5'h01 && step_down_out)
        else $error("decrease step not applied");

    gain_top_a: assert property (ce_in && next_idx == `UVS_IDX_MAX
        && !pins.se_mode |=> gain_db_out == `UVS_GAIN_TOP_DB)
        else $error("top gain wrong");

    first_step_a: assert property (do_step && !pins.ext_mode && base_phase == PH_FIRST
        |-> base_cnt == 6'h03)
        else $error("step without four sampled edges");

    ramp_second_a: assert property (do_step && !pins.ext_mode && base_phase == PH_SECOND
        |-> base_cnt == 6'h27)
        else $error("second ramp interval wrong");

    ramp_repeat_a: assert property (do_step && !pins.ext_mode && base_phase == PH_REPEAT
        |-> base_cnt == 6'h03)
        else $error("repeat interval wrong");

    step_on_edge_a: assert property (do_step |-> clk_rise && pins.main_power)
        else $error("step without rising clock edge");

    ext_count_a: assert property (do_step && pins.ext_mode |-> ext_cnt == 3'h3)
        else $error("external step not on fourth edge");

    ext_keep_a: assert property (ce_in && pins.ext_mode && !dir_valid
        |=> ext_cnt == $past(ext_cnt))
        else $error("external edge count cleared between requests");

    retain_idx_a: assert property (ce_in && pins.ret_ok && !pins.main_power
        |=> idx == $past(idx))
        else $error("index changed without main power");

    ret_loss_a: assert property (ce_in && !pins.ret_ok
        |=> idx == `UVS_IDX_RET_DEFAULT)
        else $error("retention loss default not loaded");

    saturate_a: assert property (ce_in && pins.ret_ok && do_step
        && ((req_up && idx == `UVS_IDX_MAX) || (req_down && idx == `UVS_IDX_MUTE))
        |=> $stable(idx) && !step_up_out && !step_down_out)
        else $error("index left its range");

    release_clear_a: assert property (ce_in && !pins.ext_mode && !dir_valid
        |=> phase == PH_IDLE && cnt == 6'h00)
        else $error("ramp not cleared on release");

    both_low_a: assert property (req_up && req_down |-> !do_step)
        else $error("step with both requests low");

endmodule

// [sim/updown_volume_stepper_bench.sv]
/*
 * Self-checking bench for the up/down volume stepper.
 * Assumes the host model drives the volume pins; ce_in is driven by the bench.
 */
`timescale 1ns/1ns
module updown_volume_stepper_bench;
    logic ref_clk, rst_n, ce, clk_ext, cfg_se, ret_ok, pwr_ok;
    logic pin_clk, up_n, dn_n, mute, st_up, st_dn;
    logic [4:0] idx;
    logic [7:0] gain;
    int fails = 0;
    int checked = 0;
    int up_cnt = 0;
    int dn_cnt = 0;
    int n, k;
    int gaps[6] = '{40, 20, 12, 8, 4, 4};

    uvs_updown_stepper uvs_updown_stepper_inst (
        .ref_clk_in(ref_clk), .rst_n_in(rst_n), .ce_in(ce),
        .vol_clk_pin_in(pin_clk), .vol_up_n_in(up_n), .vol_down_n_in(dn_n),
        .clk_source_ext_in(clk_ext), .output_config_select_in(cfg_se),
        .retention_supply_ok_in(ret_ok), .main_power_ok_in(pwr_ok),
        .vol_index_out(idx), .gain_db_out(gain), .mute_out(mute),
        .step_up_out(st_up), .step_down_out(st_dn)
    );
    uvs_host_model uvs_host_model_inst (
        .ref_clk_in(ref_clk), .vol_clk_pin_out(pin_clk),
        .vol_up_n_out(up_n), .vol_down_n_out(dn_n)
    );

    always #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (st_up === 1'b1) up_cnt++;
        if (st_dn === 1'b1) dn_cnt++;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] exp_gain(input int i, input bit se);
        logic [7:0] g;
        g = (i == 0) ? 8'hAB : 8'(2 * i - 42);
        return se ? g - 8'h06 : g;
    endfunction

    task automatic check_state(input int i, input bit se);
        chk("index", 8'(i), {3'h0, idx});
        chk("gain", exp_gain(i, se), gain);
        chk("mute", {7'h00, i == 0}, {7'h00, mute});
    endtask

    task automatic rises(input int r);
        bit ok;
        uvs_host_model_inst.rises(r, ok);
        if (!ok) begin
            fails++;
            $display("CHECK FAILED clock burst expected 1 seen 0");
            end_sim();
        end
    endtask

    task automatic press(input logic u, input logic d);
        uvs_host_model_inst.press(u, d);
    endtask

    task automatic wait_up(input int limit, output int w);
        int j;
        w = -1;
        for (j = 1; j <= limit; j++) begin
            @(posedge ref_clk);
            #1;
            if (st_up === 1'b1) begin
                w = j;
                break;
            end
        end
        if (w < 0) begin
            fails++;
            $display("CHECK FAILED step pulse expected 1 seen 0");
            end_sim();
        end
    endtask

    task automatic t_reset;
        check_state(0, 0);
        press(1, 0);
        rises(4);
        check_state(0, 0);
        chk("down pulses at mute", 8'h00, 8'(dn_cnt));
        press(1, 1);
    endtask

    task automatic t_ext_up;
        press(0, 1);
        rises(3);
        check_state(0, 0);
        rises(1);
        check_state(1, 0);
        chk("up pulses", 8'h01, 8'(up_cnt));
        press(1, 1);
    endtask

    task automatic t_carry;
        press(0, 1);
        rises(5);
        check_state(2, 0);
        press(1, 1);
        press(0, 1);
        rises(2);
        check_state(2, 0);
        rises(1);
        check_state(3, 0);
        press(1, 1);
    endtask

    task automatic t_down;
        press(1, 0);
        rises(4);
        check_state(2, 0);
        chk("down pulses", 8'h01, 8'(dn_cnt));
        press(0, 0);
        rises(4);
        check_state(2, 0);
        press(1, 1);
    endtask

    task automatic t_config_power;
        cfg_se <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check_state(2, 1);
        cfg_se <= 1'b0;
        pwr_ok <= 1'b0;
        repeat (8) @(posedge ref_clk);
        press(0, 1);
        rises(4);
        check_state(2, 0);
        press(1, 1);
        pwr_ok <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check_state(2, 0);
        ce <= 1'b0;
        ret_ok <= 1'b0;
        repeat (8) @(posedge ref_clk);
        ret_ok <= 1'b1;
        repeat (8) @(posedge ref_clk);
        ce <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check_state(2, 0);
    endtask

    task automatic t_ramp;
        ret_ok <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check_state(16, 0);
        ret_ok <= 1'b1;
        clk_ext <= 1'b0;
        repeat (8) @(posedge ref_clk);
        uvs_host_model_inst.run_free(1);
        press(0, 1);
        wait_up(140, n);
        chk("first step in window", 8'h01, {7'h00, n >= 40 && n <= 130});
        foreach (gaps[g]) begin
            wait_up(gaps[g] * 20 + 40, n);
            chk("step gap deviation", 8'h00, 8'(n - gaps[g] * 20));
        end
        check_state(23, 0);
        press(1, 1);
        repeat (60) @(posedge ref_clk);
        press(0, 1);
        wait_up(140, n);
        chk("restart first step", 8'h01, {7'h00, n >= 40 && n <= 130});
        wait_up(840, n);
        chk("restart second gap", 8'h00, 8'(n - 800));
        press(1, 1);
        uvs_host_model_inst.run_free(0);
        clk_ext <= 1'b1;
        repeat (40) @(posedge ref_clk);
        check_state(25, 0);
    endtask

    task automatic t_top;
        press(0, 1);
        rises(24);
        check_state(31, 0);
        k = up_cnt;
        rises(4);
        check_state(31, 0);
        chk("up pulses at top", 8'(k), 8'(up_cnt));
        press(1, 1);
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        clk_ext = 1'b1;
        cfg_se = 1'b0;
        ret_ok = 1'b1;
        pwr_ok = 1'b1;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_ext_up();
        t_carry();
        t_down();
        t_config_power();
        t_ramp();
        t_top();
        end_sim();
    end
endmodule

// [sim/uvs_host_model.sv]
/*
 * Host and push-button model for the volume pins: a gated or free-running
 * volume clock and the two active-low request pins.
 * Assumes the bench calls its tasks from one process, after a clock edge.
 */
`timescale 1ns/1ns
module uvs_host_model (
    input wire logic ref_clk_in,
    output logic vol_clk_pin_out,
    output logic vol_up_n_out,
    output logic vol_down_n_out
);
    int phase = 0;
    int done = 0;
    int req = 0;
    bit free = 0;

    initial begin
        vol_clk_pin_out = 1'b0;
        vol_up_n_out = 1'b1;
        vol_down_n_out = 1'b1;
    end

    // One rise per 20 cycles; pin rests low between bursts
    // Rise spacing is time-scaled against the device clock; edge counts matter
    always @(posedge ref_clk_in) begin
        if (phase != 0) begin
            phase <= (phase == 19) ? 0 : phase + 1;
            if (phase == 10) begin
                vol_clk_pin_out <= 1'b0;
            end
        end else if (free || done < req) begin
            phase <= 1;
            vol_clk_pin_out <= 1'b1;
            done <= done + 1;
        end
    end

    // Exactly n rises while the request is held
    task automatic rises(input int n, output bit ok);
        int k;
        ok = 1'b0;
        @(posedge ref_clk_in);
        #1;
        req = done + n;
        for (k = 0; k < 25 * n + 40; k++) begin
            @(posedge ref_clk_in);
            if (done >= req && phase == 0) begin
                ok = 1'b1;
                break;
            end
        end
    endtask

    // Buttons released go back to their pull-up level
    task automatic press(input logic up_n, input logic down_n);
        @(posedge ref_clk_in);
        vol_up_n_out <= up_n;
        vol_down_n_out <= down_n;
        repeat (8) @(posedge ref_clk_in);
    endtask

    task automatic run_free(input bit f);
        @(posedge ref_clk_in);
        #1;
        free = f;
    endtask
endmodule
